/* logic/lli_init_ctrl.sv */
// Purpose: Link layer init control, status and reserved-field check
// Assumes: Documented register port; peer keeps its side of the exchange
// Notes:   One clock; credits shown are those usable by our transmitter
//
// Operation
// - Control bits 17 and 16 halt init until software clears them.
// - Status bits 27:24 show the current init state.
// - State reads 0001 only for a control-bit stall, else 0000 waiting.
// - Status reports adaptive and VN0 credits for our transmit side.
// - A received packet with non-zero reserved check field flags an error.
// - The control-stall state shows only while stalled during init.
// - Each side sends its parameters; received ones are stored and used.
// - The router parameter we advertise is one.
module lli_init_ctrl (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // Register port
   input  wire logic               regWrite,
   input  wire logic               regRead,
   input  wire logic [7:0]         regAddr,
   input  wire logic [31:0]        regWdata,
   output logic [31:0]             regRdata,
   // Physical layer and internal stall sources
   input  wire logic               phyReady,
   input  wire logic               internalStall,
   // Parameter exchange with the peer
   output lli_pkg::lli_param_s     txParam,
   output logic                    txParamValid,
   input  wire logic               txParamReady,
   input  wire lli_pkg::lli_param_s rxParam,
   input  wire logic               rxParamValid,
   // Packet check and credit traffic
   input  wire lli_pkg::lli_pkt_s  rxPkt,
   input  wire logic               useAdapt,
   input  wire logic               useVn0,
   input  wire logic               retAdapt,
   input  wire logic               retVn0,
   // Status
   output logic                    linkUp,
   output logic                    unsupportedPktErr,
   output logic [1:0]              crcMode
);
   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   logic [31:0] linkControl;
   logic [31:0] next_linkControl;
   logic        ctrlStall;

   always_comb begin
      next_linkControl = linkControl;
      if (regWrite && regAddr == lli_pkg::LINK_CONTROL_OFFSET) begin
         next_linkControl = regWdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         linkControl <= lli_pkg::LINK_CONTROL_RESET;
      end else begin
         linkControl <= next_linkControl;
      end
   end

   assign ctrlStall = linkControl[lli_pkg::STALL_HI_BIT] |
                      linkControl[lli_pkg::STALL_LO_BIT];
   // CRC mode is held for software; only 8-bit CRC is built
   assign crcMode = linkControl[lli_pkg::CRC_MODE_HI:lli_pkg::CRC_MODE_LO];

   // ----------------------------------------------------------------------
   // Init state machine
   // ----------------------------------------------------------------------
   lli_pkg::lli_state_e state;
   lli_pkg::lli_state_e next_state;
   lli_pkg::lli_param_s peerParam;
   lli_pkg::lli_param_s next_peerParam;
   logic                gotParam;
   logic                next_gotParam;
   logic                sentParam;
   logic                next_sentParam;
   logic                loadCred;

   always_comb begin
      next_state     = state;
      next_peerParam = peerParam;
      next_gotParam  = gotParam;
      next_sentParam = sentParam;
      loadCred       = 1'b0;
      // Parameters can arrive before ours are sent; keep them
      if (rxParamValid && state != lli_pkg::LLI_PHY_WAIT &&
          state != lli_pkg::LLI_ACTIVE) begin
         next_peerParam = rxParam;
         next_gotParam  = 1'b1;
      end
      if (txParamValid && txParamReady) begin
         next_sentParam = 1'b1;
      end
      if (!phyReady) begin
         next_state     = lli_pkg::LLI_PHY_WAIT;
         next_gotParam  = 1'b0;
         next_sentParam = 1'b0;
      end else if (!ctrlStall) begin
         case (state)
            lli_pkg::LLI_PHY_WAIT: begin
               if (!internalStall) begin
                  next_state = lli_pkg::LLI_SEND;
               end
            end
            lli_pkg::LLI_SEND: begin
               if (next_sentParam) begin
                  next_state = lli_pkg::LLI_RECV;
               end
            end
            lli_pkg::LLI_RECV: begin
               if (next_gotParam) begin
                  next_state = lli_pkg::LLI_ACTIVE;
                  loadCred   = 1'b1;
               end
            end
            lli_pkg::LLI_ACTIVE: begin
               next_state = lli_pkg::LLI_ACTIVE;
            end
            default: begin
               next_state = lli_pkg::LLI_PHY_WAIT;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state     <= lli_pkg::LLI_PHY_WAIT;
         peerParam <= '0;
         gotParam  <= 1'b0;
         sentParam <= 1'b0;
      end else begin
         state     <= next_state;
         peerParam <= next_peerParam;
         gotParam  <= next_gotParam;
         sentParam <= next_sentParam;
      end
   end

   // Our advertised parameters
   always_comb begin
      txParam              = '0;
      txParam.router       = lli_pkg::ROUTER_VALUE;
      txParam.adaptCredits = 8'h10;
      txParam.vn0Credits   = 8'h04;
      txParam.reserved     = lli_pkg::RSVD_ZERO;
   end
   assign txParamValid = (state == lli_pkg::LLI_SEND) && !sentParam &&
                         !ctrlStall && phyReady;
   assign linkUp = (state == lli_pkg::LLI_ACTIVE);

   // ----------------------------------------------------------------------
   // Status encoding
   // ----------------------------------------------------------------------
   logic [3:0] initState;

   always_comb begin
      case (state)
         lli_pkg::LLI_SEND:   initState = lli_pkg::INIT_SEND_PARM;
         lli_pkg::LLI_RECV:   initState = lli_pkg::INIT_WAIT_PARM;
         lli_pkg::LLI_ACTIVE: initState = lli_pkg::INIT_DONE;
         default:             initState = lli_pkg::INIT_WAIT_PHY;
      endcase
      // Only the control bits show as stall; other stalls look like
      // plain waiting
      if (ctrlStall && phyReady && state != lli_pkg::LLI_ACTIVE) begin
         initState = lli_pkg::INIT_STALL;
      end
   end

   // ----------------------------------------------------------------------
   // Transmit credits and reserved field check
   // ----------------------------------------------------------------------
   logic [7:0] adaptAvail;
   logic [7:0] vn0Avail;
   logic       next_unsupportedPktErr;

   // Peer's grant is what our transmitter may spend
   lli_credit_track u_credit (
      .clk        (clk),
      .rst_b      (rst_b),
      .load       (loadCred),
      .loadAdapt  (next_peerParam.adaptCredits),
      .loadVn0    (next_peerParam.vn0Credits),
      .useAdapt   (useAdapt && linkUp),
      .useVn0     (useVn0 && linkUp),
      .retAdapt   (retAdapt && linkUp),
      .retVn0     (retVn0 && linkUp),
      .adaptAvail (adaptAvail),
      .vn0Avail   (vn0Avail)
   );

   always_comb begin
      next_unsupportedPktErr = rxPkt.valid &&
         (rxPkt.reservedCheckField != lli_pkg::RSVD_ZERO);
   end

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   logic [31:0] statusWord;
   logic [31:0] next_regRdata;

   always_comb begin
      statusWord = '0;
      statusWord[lli_pkg::INIT_STATE_HI:lli_pkg::INIT_STATE_LO] =
         initState;
      statusWord[lli_pkg::ADAPT_CRED_LO +: lli_pkg::CRED_W] = adaptAvail;
      statusWord[lli_pkg::VN0_CRED_LO +: lli_pkg::CRED_W]   = vn0Avail;
      next_regRdata = regRdata;
      if (regRead) begin
         case (regAddr)
            lli_pkg::LINK_CONTROL_OFFSET: next_regRdata = linkControl;
            lli_pkg::LINK_STATUS_OFFSET:  next_regRdata = statusWord;
            default:                      next_regRdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regRdata          <= 32'h0000_0000;
         unsupportedPktErr <= 1'b0;
      end else begin
         regRdata          <= next_regRdata;
         unsupportedPktErr <= next_unsupportedPktErr;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   // A control stall with the physical layer ready holds the init state
   a_stall_holds: assert property (
      @(posedge clk) disable iff (!rst_b)
      ctrlStall && phyReady && state != lli_pkg::LLI_ACTIVE
      |=> $stable(state))
      else $error("init advanced while stalled");
   a_stall_code: assert property (
      @(posedge clk) disable iff (!rst_b)
      (initState == lli_pkg::INIT_STALL) |-> ctrlStall)
      else $error("stall code without control stall");
   a_internal_wait: assert property (
      @(posedge clk) disable iff (!rst_b)
      internalStall && !ctrlStall && state == lli_pkg::LLI_PHY_WAIT
      |-> initState == lli_pkg::INIT_WAIT_PHY)
      else $error("internal stall not shown as waiting");
   a_status_read: assert property (
      @(posedge clk) disable iff (!rst_b)
      regRead && regAddr == lli_pkg::LINK_STATUS_OFFSET
      |=> regRdata[27:24] == $past(initState))
      else $error("status field mismatch");
   a_rsvd_flag: assert property (
      @(posedge clk) disable iff (!rst_b)
      rxPkt.valid && rxPkt.reservedCheckField != 8'h00
      |=> unsupportedPktErr)
      else $error("reserved field error missed");
   a_router_one: assert property (
      @(posedge clk) disable iff (!rst_b)
      txParamValid |-> txParam.router == 8'h01)
      else $error("router value not one");
   a_resume_send: assert property (
      @(posedge clk) disable iff (!rst_b)
      $fell(ctrlStall) && phyReady && state == lli_pkg::LLI_SEND
      |-> txParamValid || sentParam)
      else $error("init did not resume");
   a_cred_load: assert property (
      @(posedge clk) disable iff (!rst_b)
      loadCred |=> adaptAvail == $past(next_peerParam.adaptCredits)
      && linkUp)
      else $error("tx credits not loaded from peer");
   a_stall_active: assert property (
      @(posedge clk) disable iff (!rst_b)
      linkUp |-> initState != lli_pkg::INIT_STALL)
      else $error("stall shown after init");
   c_link_up: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(linkUp));
   c_stall_then_up: cover property (@(posedge clk) disable iff (!rst_b)
      initState == lli_pkg::INIT_STALL ##[1:200] linkUp);
   c_rsvd_err: cover property (@(posedge clk) disable iff (!rst_b)
      unsupportedPktErr);
endmodule

/* inc/lli_pkg.sv */
// Purpose: Shared constants and types for the link init control block
// Assumes: 32-bit register port, one clock, async active-low reset
// Notes:   Field positions and offsets are named once here
package lli_pkg;
   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] LINK_CONTROL_OFFSET = 8'h44;
   localparam logic [7:0] LINK_STATUS_OFFSET  = 8'h48;
   localparam int STALL_HI_BIT   = 17;
   localparam int STALL_LO_BIT   = 16;
   localparam int CRC_MODE_HI    = 15;
   localparam int CRC_MODE_LO    = 14;
   localparam int INIT_STATE_HI  = 27;
   localparam int INIT_STATE_LO  = 24;
   localparam int ADAPT_CRED_LO  = 0;
   localparam int VN0_CRED_LO    = 8;
   localparam int CRED_W         = 8;
   localparam logic [31:0] LINK_CONTROL_RESET = 32'h0000_0000;
   localparam logic [1:0]  CRC_MODE_8BIT      = 2'h0;
   // ----------------------------------------------------------------------
   // Init state encodings
   // ----------------------------------------------------------------------
   localparam logic [3:0] INIT_WAIT_PHY  = 4'h0;
   localparam logic [3:0] INIT_STALL     = 4'h1;
   localparam logic [3:0] INIT_SEND_PARM = 4'h2;
   localparam logic [3:0] INIT_WAIT_PARM = 4'h3;
   localparam logic [3:0] INIT_DONE      = 4'h6;
   localparam logic [7:0] ROUTER_VALUE   = 8'h01;
   localparam logic [7:0] RSVD_ZERO      = 8'h00;

   typedef enum logic [2:0] {
      LLI_PHY_WAIT, LLI_SEND, LLI_RECV, LLI_ACTIVE
   } lli_state_e;

   // Link parameter word exchanged at init
   typedef struct packed {
      logic [7:0] router;
      logic [7:0] adaptCredits;
      logic [7:0] vn0Credits;
      logic [7:0] reserved;
   } lli_param_s;

   // Inbound packet header fields checked by the target
   typedef struct packed {
      logic       valid;
      logic [7:0] reservedCheckField;
   } lli_pkt_s;
endpackage

/* logic/lli_credit_track.sv */
// Purpose: Transmit-side credit counters for adaptive and VN0 nets
// Assumes: Peer grants credits in its init parameters, returns one at a time
// Notes:   Counters saturate; never underflow
module lli_credit_track (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Initial grant from the peer
   input  wire logic        load,
   input  wire logic [7:0]  loadAdapt,
   input  wire logic [7:0]  loadVn0,
   // Credit traffic
   input  wire logic        useAdapt,
   input  wire logic        useVn0,
   input  wire logic        retAdapt,
   input  wire logic        retVn0,
   // Available counts
   output logic [7:0]       adaptAvail,
   output logic [7:0]       vn0Avail
);
   logic [7:0] next_adaptAvail;
   logic [7:0] next_vn0Avail;

   function automatic logic [7:0] step(input logic [7:0] c,
                                       input logic u, input logic r);
      logic [7:0] n;
      n = c;
      if (r && !u && c != 8'hFF) begin
         n = c + 8'h01;
      end else if (u && !r && c != 8'h00) begin
         n = c - 8'h01;
      end
      return n;
   endfunction

   always_comb begin
      next_adaptAvail = step(adaptAvail, useAdapt, retAdapt);
      next_vn0Avail   = step(vn0Avail, useVn0, retVn0);
      if (load) begin
         next_adaptAvail = loadAdapt;
         next_vn0Avail   = loadVn0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         adaptAvail <= 8'h00;
         vn0Avail   <= 8'h00;
      end else begin
         adaptAvail <= next_adaptAvail;
         vn0Avail   <= next_vn0Avail;
      end
   end
endmodule

/* dv/lli_peer_model.sv */
// Purpose: Peer link agent for the init parameter exchange
// Assumes: Signals change just after the rising edge
// Notes:   Delay sets how slow the peer is to accept our parameters
module lli_peer_model (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // Exchange with the block
   input  wire lli_pkg::lli_param_s txParam,
   input  wire logic                txParamValid,
   output logic                     txParamReady,
   output lli_pkg::lli_param_s      rxParam,
   output logic                     rxParamValid,
   // Bench control and view
   input  wire logic [7:0]          delay,
   input  wire logic [7:0]          grantAdapt,
   input  wire logic [7:0]          grantVn0,
   output lli_pkg::lli_param_s      seenParam
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   logic       sendNow;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txParamReady <= 1'b0;
         rxParamValid <= 1'b0;
         rxParam      <= '0;
         seenParam    <= '0;
         cnt          <= 8'h00;
         sendNow      <= 1'b0;
      end else begin
         rxParamValid <= 1'b0;
         // Outside the strobe the word keeps toggling, never stale
         rxParam      <= ~rxParam;
         if (txParamReady && txParamValid) begin
            seenParam    <= txParam;
            txParamReady <= 1'b0;
            sendNow      <= 1'b1;
         end else if (sendNow) begin
            rxParam      <= '{router: 8'h01, adaptCredits: grantAdapt,
                              vn0Credits: grantVn0, reserved: 8'h00};
            rxParamValid <= 1'b1;
            sendNow      <= 1'b0;
            cnt          <= 8'h00;
         end else if (!txParamValid) begin
            txParamReady <= 1'b0;
            cnt          <= 8'h00;
         end else if (!txParamReady) begin
            if (cnt >= delay) begin
               txParamReady <= 1'b1;
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   end
endmodule

/* dv/link_layer_init_control_tb.sv */
// Purpose: Self-checking bench for the link init control block
// Assumes: Inputs change on the falling edge
// Notes:   Peer model answers slowly first, promptly on relink
module link_layer_init_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, regWrite, regRead, phyReady, internalStall;
   logic [7:0] regAddr, delay, grantAdapt, grantVn0;
   logic [31:0] regWdata, regRdata, d;
   lli_pkg::lli_param_s txParam, rxParam, seenParam;
   logic txParamValid, txParamReady, rxParamValid, linkUp;
   logic useAdapt, useVn0, retAdapt, retVn0, unsupportedPktErr;
   logic [1:0] crcMode;
   lli_pkg::lli_pkt_s rxPkt;
   int err_count = 0;
   int total_checks = 0;
   localparam logic [7:0] CTL = lli_pkg::LINK_CONTROL_OFFSET;
   localparam logic [7:0] STS = lli_pkg::LINK_STATUS_OFFSET;

   lli_init_ctrl dut (.clk(clk), .rst_b(rst_b), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata(regRdata), .phyReady(phyReady),
      .internalStall(internalStall), .txParam(txParam),
      .txParamValid(txParamValid), .txParamReady(txParamReady),
      .rxParam(rxParam), .rxParamValid(rxParamValid), .rxPkt(rxPkt),
      .useAdapt(useAdapt), .useVn0(useVn0), .retAdapt(retAdapt),
      .retVn0(retVn0), .linkUp(linkUp),
      .unsupportedPktErr(unsupportedPktErr), .crcMode(crcMode));
   lli_peer_model peer (.clk(clk), .rst_b(rst_b), .txParam(txParam),
      .txParamValid(txParamValid), .txParamReady(txParamReady),
      .rxParam(rxParam), .rxParamValid(rxParamValid), .delay(delay),
      .grantAdapt(grantAdapt), .grantVn0(grantVn0),
      .seenParam(seenParam));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic regWr(input logic [7:0] a, input logic [31:0] v);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr  = a;
      regWdata = v;
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task automatic regRd(input logic [7:0] a);
      @(negedge clk);
      regRead = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRead = 1'b0;
      d       = regRdata;
   endtask
   task automatic waitLink();
      for (int i = 0; i < 40 && linkUp !== 1'b1; i++) @(negedge clk);
      chk("linkUp", 32'h1, {31'h0, linkUp});
      if (linkUp !== 1'b1) conclude();
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic tRegs();
      regRd(CTL);
      chk("ctrl reset", lli_pkg::LINK_CONTROL_RESET, d);
      chk("crcMode", 32'h0, {30'h0, crcMode});
      regWr(CTL, 32'h5A00_0000);
      regWr(STS, 32'hFFFF_FFFF);
      regRd(CTL);
      chk("ctrl rw", 32'h5A00_0000, d);
      regRd(STS);
      chk("state idle", 32'h0, {28'h0, d[27:24]});
      regRd(8'h4C);
      chk("unmapped", 32'h0, d);
      regWr(CTL, 32'h0000_0000);
   endtask
   task automatic tStall();
      phyReady = 1'b1;
      internalStall = 1'b1;
      repeat (3) @(negedge clk);
      regRd(STS);
      chk("internal stall", 32'h0, {28'h0, d[27:24]});
      regWr(CTL, 32'h0001_0000);
      internalStall = 1'b0;
      repeat (4) @(negedge clk);
      regRd(STS);
      chk("bit16 stall", 32'h1, {28'h0, d[27:24]});
      regWr(CTL, 32'h0002_0000);
      repeat (4) @(negedge clk);
      regRd(STS);
      chk("bit17 stall", 32'h1, {28'h0, d[27:24]});
      chk("held", 32'h0, {31'h0, txParamValid});
      regWr(CTL, 32'h0000_0000);
      regRd(STS);
      chk("resumed", 32'h2, {28'h0, d[27:24]});
      chk("router", 32'h1, {24'h0, txParam.router});
   endtask
   task automatic tLink(input logic [7:0] ga, input logic [7:0] gv);
      waitLink();
      regRd(STS);
      chk("state done", 32'h6, {28'h0, d[27:24]});
      chk("tx credits", {16'h0, gv, ga}, {16'h0, d[15:0]});
      chk("peer got", 32'h1, {24'h0, seenParam.router});
   endtask
   task automatic tCredits();
      pulse(useAdapt);
      pulse(retVn0);
      regRd(STS);
      chk("credit use", 32'h1F, {24'h0, d[7:0]});
      chk("credit ret", 32'h08, {24'h0, d[15:8]});
      regWr(CTL, 32'h0001_0000);
      regRd(STS);
      chk("no stall shown", 32'h6, {28'h0, d[27:24]});
      regWr(CTL, 32'h0000_0000);
   endtask
   task automatic tPkt(input logic [7:0] f, input logic e);
      @(negedge clk);
      rxPkt = '{valid: 1'b1, reservedCheckField: f};
      @(negedge clk);
      rxPkt = '{valid: 1'b0, reservedCheckField: 8'h00};
      chk("pkt err", {31'h0, e}, {31'h0, unsupportedPktErr});
      @(negedge clk);
      chk("pkt err end", 32'h0, {31'h0, unsupportedPktErr});
   endtask
   task automatic tRelink();
      pulse(useVn0);
      pulse(retAdapt);
      regRd(STS);
      chk("credit back", 32'h0720, {16'h0, d[15:0]});
      phyReady = 1'b0;
      repeat (2) @(negedge clk);
      chk("link down", 32'h0, {31'h0, linkUp});
      delay = 8'h00;
      grantAdapt = 8'h03;
      grantVn0 = 8'h7F;
      phyReady = 1'b1;
      tLink(8'h03, 8'h7F);
   endtask

   // ----------------------------------------------------------------
   // Clock, reset and run
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      conclude();
   end
   initial begin
      {rst_b, regWrite, regRead, phyReady, internalStall} = 5'h00;
      {useAdapt, useVn0, retAdapt, retVn0} = 4'h0;
      regAddr = 8'h00;
      regWdata = 32'h0000_0000;
      rxPkt = '0;
      delay = 8'h0A;
      grantAdapt = 8'h20;
      grantVn0 = 8'h07;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      tRegs();
      tStall();
      tLink(8'h20, 8'h07);
      tCredits();
      tPkt(8'h00, 1'b0);
      tPkt(8'h80, 1'b1);
      tRelink();
      conclude();
   end
endmodule
